// ==== iobad_host_model.sv ====
// host processor model: configuration cycles and i/o address cycles
`timescale 1ns/1ns
`default_nettype none

module iobad_host_model
  import iobad_pkg::*;
(
  input  wire logic        clk_i,    // bench clock
  output var  logic        mode_o,   // configuration mode
  output var  logic        idx_wr_o, // index write strobe
  output var  logic        dat_wr_o, // data write strobe
  output var  logic [7:0]  wdata_o,  // write data
  output var  iobad_host_t host_o    // chip select and address
);
  // idle bus at time zero, host deselected
  initial
  begin
    mode_o   = 1'b0;
    idx_wr_o = 1'b0;
    dat_wr_o = 1'b0;
    wdata_o  = 8'h00;
    host_o   = '{host_select_n: 1'b1, addr: 11'h000};
  end

  // index cycle only, leaves configuration mode on
  task automatic cfg_idx(input logic [7:0] idx);
    @(negedge clk_i);
    mode_o   <= 1'b1;
    idx_wr_o <= 1'b1;
    wdata_o  <= idx;
    @(negedge clk_i);
    idx_wr_o <= 1'b0;
    wdata_o  <= ~idx;  // released data must not look valid
  endtask : cfg_idx

  // index then data, back to back; m low tries a refused write
  task automatic cfg_wr(input logic m, input logic [7:0] idx,
                        input logic [7:0] dat);
    @(negedge clk_i);
    mode_o   <= m;
    idx_wr_o <= 1'b1;
    wdata_o  <= idx;
    @(negedge clk_i);
    idx_wr_o <= 1'b0;
    dat_wr_o <= 1'b1;
    wdata_o  <= dat;
    @(negedge clk_i);
    dat_wr_o <= 1'b0;
    wdata_o  <= ~dat;
  endtask : cfg_wr

  // i/o cycle: pins held until the next call
  task automatic io(input logic sel_n, input logic [10:0] a);
    @(negedge clk_i);
    host_o <= '{host_select_n: sel_n, addr: a};
  endtask : io
endmodule : iobad_host_model

`default_nettype wire

// ==== iobad_pkg.sv ====
// package of constants and carriers for the i/o base address decoder
`default_nettype none

package iobad_pkg;

  // ---------------------------------------------------------------
  // configuration indices
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_GAME_SELECT_BASE    = 8'h1e;
  localparam logic [7:0] IDX_DRIVE_TYPE_SELECT   = 8'h1f;
  localparam logic [7:0] IDX_FLOPPY_BASE         = 8'h20;
  localparam logic [7:0] IDX_IDE_CONTROL_BASE    = 8'h21;
  localparam logic [7:0] IDX_IDE_ALT_STATUS_BASE = 8'h22;
  localparam logic [7:0] IDX_PARALLEL_PORT_BASE  = 8'h23;
  localparam logic [7:0] IDX_SERIAL_PORT_ONE     = 8'h24;
  localparam logic [7:0] IDX_SERIAL_PORT_TWO     = 8'h25;

  // ---------------------------------------------------------------
  // power-up values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_GAME_SELECT_BASE    = 8'h80;
  localparam logic [7:0] RST_DRIVE_TYPE_SELECT   = 8'h00;
  localparam logic [7:0] RST_FLOPPY_BASE         = 8'h3c;
  localparam logic [7:0] RST_IDE_CONTROL_BASE    = 8'h3c;
  localparam logic [7:0] RST_IDE_ALT_STATUS_BASE = 8'h3d;
  localparam logic [7:0] RST_PARALLEL_PORT_BASE  = 8'h00;
  localparam logic [7:0] RST_SERIAL_PORT_BASE    = 8'h00;
  localparam logic [7:0] RST_INDEX               = 8'h00;

  // ---------------------------------------------------------------
  // field values
  // ---------------------------------------------------------------
  localparam logic [1:0] FIX_ZERO_LOW    = 2'h0;  // floppy / ide low bits
  localparam logic [1:0] FIX_ALT_LOW     = 2'h1;  // alt status low bits
  localparam logic [1:0] GAME_OFF        = 2'h0;
  localparam logic [1:0] GAME_ONE_BYTE   = 2'h1;
  localparam logic [1:0] GAME_EIGHT_BYTE = 2'h2;
  localparam logic [1:0] GAME_SIXTEEN    = 2'h3;
  localparam logic [3:0] GAME_BYTE_LOW   = 4'h1;  // low nibble, one byte
  localparam logic [3:0] ALT_STATUS_LOW  = 4'h6;  // low nibble, alt status
  localparam logic [1:0] TYPE_DENS       = 2'h0;
  localparam logic [1:0] TYPE_RATES      = 2'h1;
  localparam logic [1:0] TYPE_INV_DENS   = 2'h2;
  localparam logic [1:0] TYPE_SWAPPED    = 2'h3;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        host_select_n;  // host chip select, low active
    logic [10:0] addr;           // host address bits 10:0
  } iobad_host_t;

  typedef struct packed {
    logic density_select;        // density select from floppy core
    logic rate_bit_one;          // data rate bit 1
    logic rate_bit_zero;         // data rate bit 0
  } iobad_rate_t;

endpackage : iobad_pkg

`default_nettype wire

// ==== iobad_top.sv ====
// configuration registers and i/o base address decoder
`timescale 1ns/1ns
`default_nettype none

module iobad_top
  import iobad_pkg::*;
(
  input  wire logic        REF_CLK_I,         // 50 mhz clock
  input  wire logic        RESET_I,           // sync reset, high
  // configuration access
  input  wire logic        CFG_MODE_I,        // configuration mode active
  input  wire logic        CFG_INDEX_WR_I,    // write index register
  input  wire logic        CFG_DATA_WR_I,     // write indexed register
  input  wire logic [7:0]  CFG_WDATA_I,       // write data
  output logic      [7:0]  CFG_RDATA_O,       // indexed register value
  // host address pins
  input  wire logic        HOST_SELECT_N_I,   // host chip select, low
  input  wire logic [10:0] HOST_ADDR_I,       // host address 10:0
  // mode inputs from other configuration logic
  input  wire logic        POWER_GOOD_CTRL_I, // pin used as power good
  input  wire logic        EPP_MODE_I,        // enhanced parallel mode
  input  wire logic        ECP_MODE_I,        // extended capabilities mode
  // floppy core signals
  input  wire logic [1:0]  DRIVE_SEL_I,       // currently selected drive
  input  wire logic        DENSITY_SELECT_I,  // density select
  input  wire logic        RATE_BIT_ONE_I,    // data rate bit 1
  input  wire logic        RATE_BIT_ZERO_I,   // data rate bit 0
  output logic             DENSITY_OUT_ZERO_O,
  output logic             DENSITY_OUT_ONE_O,
  // decode selects, high active
  output logic             GAME_PORT_SELECT_O,
  output logic             FLOPPY_SELECT_O,
  output logic             IDE_CONTROL_SELECT_O,
  output logic             IDE_ALT_SELECT_O,
  output logic             PARALLEL_SELECT_O,
  output logic             SERIAL_ONE_SELECT_O,
  output logic             SERIAL_TWO_SELECT_O
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]  config_index_register;  // selected configuration index
  logic [7:0]  game_select_base;       // game base and decode mode
  logic [7:0]  drive_type_select;      // two type bits per drive
  logic [7:0]  floppy_base;            // floppy base, bits 9:4
  logic [7:0]  ide_control_base;       // ide control base, bits 9:4
  logic [7:0]  ide_alt_status_base;    // alt status base, bits 9:4
  logic [7:0]  parallel_port_base;     // parallel base, bits 9:2
  logic [7:0]  serial_port_one_base;   // serial one base, bits 9:3
  logic [7:0]  serial_port_two_base;   // serial two base, bits 9:3
  iobad_host_t host_meta;              // first sync stage, unread else
  iobad_host_t host;                   // synchronised host pins
  iobad_rate_t rate;                   // floppy core signals bundled
  logic        cfg_write;              // qualified data write
  logic        upper_ok;               // select low and a10 low
  logic [1:0]  cur_type;               // type of the selected drive
  logic        next_game;
  logic        next_floppy;
  logic        next_ide_ctl;
  logic        next_ide_alt;
  logic        next_parallel;
  logic        next_serial_one;
  logic        next_serial_two;

  assign rate = '{density_select: DENSITY_SELECT_I,
                  rate_bit_one:   RATE_BIT_ONE_I,
                  rate_bit_zero:  RATE_BIT_ZERO_I};

  // writes outside configuration mode are dropped
  assign cfg_write = CFG_MODE_I && CFG_DATA_WR_I;

  // ---------------------------------------------------------------
  // host pin synchroniser
  // ---------------------------------------------------------------
  // two stages, since the host bus is not timed to this clock
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      host_meta <= '{host_select_n: 1'b1, addr: 11'h000};
      host      <= '{host_select_n: 1'b1, addr: 11'h000};
    end
    else
    begin
      host_meta <= '{host_select_n: HOST_SELECT_N_I, addr: HOST_ADDR_I};
      host      <= host_meta;
    end
  end

  // ---------------------------------------------------------------
  // index register
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      config_index_register <= RST_INDEX;
    else if (CFG_MODE_I && CFG_INDEX_WR_I)
      config_index_register <= CFG_WDATA_I;
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // fixed low bits are forced on write so reads always show them
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      game_select_base     <= RST_GAME_SELECT_BASE;
      drive_type_select    <= RST_DRIVE_TYPE_SELECT;
      floppy_base          <= RST_FLOPPY_BASE;
      ide_control_base     <= RST_IDE_CONTROL_BASE;
      ide_alt_status_base  <= RST_IDE_ALT_STATUS_BASE;
      parallel_port_base   <= RST_PARALLEL_PORT_BASE;
      serial_port_one_base <= RST_SERIAL_PORT_BASE;
      serial_port_two_base <= RST_SERIAL_PORT_BASE;
    end
    else if (cfg_write)
    begin
      unique case (config_index_register)
        IDX_GAME_SELECT_BASE:    game_select_base <= CFG_WDATA_I;
        IDX_DRIVE_TYPE_SELECT:   drive_type_select <= CFG_WDATA_I;
        IDX_FLOPPY_BASE:
          floppy_base <= {CFG_WDATA_I[7:2], FIX_ZERO_LOW};
        IDX_IDE_CONTROL_BASE:
          ide_control_base <= {CFG_WDATA_I[7:2], FIX_ZERO_LOW};
        IDX_IDE_ALT_STATUS_BASE:
          ide_alt_status_base <= {CFG_WDATA_I[7:2], FIX_ALT_LOW};
        IDX_PARALLEL_PORT_BASE:  parallel_port_base <= CFG_WDATA_I;
        IDX_SERIAL_PORT_ONE:
          serial_port_one_base <= {CFG_WDATA_I[7:1], 1'b0};
        IDX_SERIAL_PORT_TWO:
          serial_port_two_base <= {CFG_WDATA_I[7:1], 1'b0};
        // other indices belong to other blocks
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  // registered, so a read shows the index held one cycle earlier
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I || !CFG_MODE_I)
      CFG_RDATA_O <= 8'h00;
    else
    begin
      unique case (config_index_register)
        IDX_GAME_SELECT_BASE:    CFG_RDATA_O <= game_select_base;
        IDX_DRIVE_TYPE_SELECT:   CFG_RDATA_O <= drive_type_select;
        IDX_FLOPPY_BASE:         CFG_RDATA_O <= floppy_base;
        IDX_IDE_CONTROL_BASE:    CFG_RDATA_O <= ide_control_base;
        IDX_IDE_ALT_STATUS_BASE: CFG_RDATA_O <= ide_alt_status_base;
        IDX_PARALLEL_PORT_BASE:  CFG_RDATA_O <= parallel_port_base;
        IDX_SERIAL_PORT_ONE:     CFG_RDATA_O <= serial_port_one_base;
        IDX_SERIAL_PORT_TWO:     CFG_RDATA_O <= serial_port_two_base;
        default:                 CFG_RDATA_O <= 8'h00;  // not ours
      endcase
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // upper qualification
  assign upper_ok = !host.host_select_n && !host.addr[10];

  always_comb
  begin
    next_game = upper_ok && game_select_base[7:4] != 4'h0 &&
                game_select_base[7:2] == host.addr[9:4];
    unique case (game_select_base[1:0])
      GAME_OFF:        next_game = 1'b0;
      GAME_ONE_BYTE:   next_game = next_game &&
                                   host.addr[3:0] == GAME_BYTE_LOW;
      GAME_EIGHT_BYTE: next_game = next_game && !host.addr[3];
      GAME_SIXTEEN:    next_game = next_game;
    endcase
    // disabled while base bits 9 and 8 are clear
    if (game_select_base[7:6] == 2'h0)
      next_game = 1'b0;
    if (POWER_GOOD_CTRL_I)
      next_game = 1'b0;
    next_floppy = upper_ok && floppy_base[7:6] != 2'h0 &&
                  floppy_base[7:2] == host.addr[9:4] && !host.addr[3];
    next_ide_ctl = upper_ok && ide_control_base[7:6] != 2'h0 &&
                   ide_control_base[7:2] == host.addr[9:4] &&
                   !host.addr[3];
    next_ide_alt = upper_ok && ide_alt_status_base[7:6] != 2'h0 &&
                   ide_alt_status_base[7:2] == host.addr[9:4] &&
                   host.addr[3:0] == ALT_STATUS_LOW;
    next_parallel = !host.host_select_n &&
                    parallel_port_base[7:6] != 2'h0 &&
                    parallel_port_base[7:1] == host.addr[9:3] &&
                    (EPP_MODE_I ||
                     parallel_port_base[0] == host.addr[2]);
    // ecp lets the upper register bank through
    if (!ECP_MODE_I && host.addr[10])
      next_parallel = 1'b0;
    next_serial_one = upper_ok && serial_port_one_base[7:6] != 2'h0 &&
                      serial_port_one_base[7:1] == host.addr[9:3];
    next_serial_two = upper_ok && serial_port_two_base[7:6] != 2'h0 &&
                      serial_port_two_base[7:1] == host.addr[9:3];
  end

  // ---------------------------------------------------------------
  // select registers
  // ---------------------------------------------------------------
  // overlapping matches are passed on, not arbitrated
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      GAME_PORT_SELECT_O   <= 1'b0;
      FLOPPY_SELECT_O      <= 1'b0;
      IDE_CONTROL_SELECT_O <= 1'b0;
      IDE_ALT_SELECT_O     <= 1'b0;
      PARALLEL_SELECT_O    <= 1'b0;
      SERIAL_ONE_SELECT_O  <= 1'b0;
      SERIAL_TWO_SELECT_O  <= 1'b0;
    end
    else
    begin
      GAME_PORT_SELECT_O   <= next_game;
      FLOPPY_SELECT_O      <= next_floppy;
      IDE_CONTROL_SELECT_O <= next_ide_ctl;
      IDE_ALT_SELECT_O     <= next_ide_alt;
      PARALLEL_SELECT_O    <= next_parallel;
      SERIAL_ONE_SELECT_O  <= next_serial_one;
      SERIAL_TWO_SELECT_O  <= next_serial_two;
    end
  end

  // ---------------------------------------------------------------
  // drive density routing
  // ---------------------------------------------------------------
  // pair of the selected drive; its high bit is type bit one
  assign cur_type = drive_type_select[{DRIVE_SEL_I, 1'b0} +: 2];

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      DENSITY_OUT_ZERO_O <= 1'b0;
      DENSITY_OUT_ONE_O  <= 1'b0;
    end
    else
    begin
      unique case (cur_type)
        TYPE_DENS:
        begin
          DENSITY_OUT_ZERO_O <= rate.density_select;
          DENSITY_OUT_ONE_O  <= rate.rate_bit_zero;
        end
        TYPE_RATES:
        begin
          DENSITY_OUT_ZERO_O <= rate.rate_bit_one;
          DENSITY_OUT_ONE_O  <= rate.rate_bit_zero;
        end
        TYPE_INV_DENS:
        begin
          DENSITY_OUT_ZERO_O <= !rate.density_select;
          DENSITY_OUT_ONE_O  <= rate.rate_bit_zero;
        end
        TYPE_SWAPPED:
        begin
          DENSITY_OUT_ZERO_O <= rate.rate_bit_zero;
          DENSITY_OUT_ONE_O  <= rate.rate_bit_one;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_game_reset_value:
    assert property (@(posedge REF_CLK_I)
      $fell(RESET_I) |-> game_select_base == RST_GAME_SELECT_BASE)
    else $error("game base not 80h after reset");
  a_cfg_write_guard:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      !$past(CFG_MODE_I) |-> $stable(game_select_base))
    else $error("game base changed outside configuration mode");
  a_game_upper_qual:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      GAME_PORT_SELECT_O |-> $past(upper_ok) && !$past(POWER_GOOD_CTRL_I)
        && $past(game_select_base[1:0]) != GAME_OFF)
    else $error("game select without qualification");
  a_floppy_block:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      FLOPPY_SELECT_O |-> $past(floppy_base[7:2]) == $past(host.addr[9:4])
        && !$past(host.addr[3]) && $past(floppy_base[7:6]) != 2'h0)
    else $error("floppy select outside its block");
  a_fixed_low_bits:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      floppy_base[1:0] == FIX_ZERO_LOW &&
      ide_alt_status_base[1:0] == FIX_ALT_LOW &&
      !serial_port_one_base[0])
    else $error("fixed low bits disturbed");
  a_alt_status_low:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      IDE_ALT_SELECT_O |-> $past(host.addr[3:0]) == ALT_STATUS_LOW)
    else $error("alt status select on wrong low nibble");
  a_parallel_a10:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      PARALLEL_SELECT_O && !$past(ECP_MODE_I) |-> !$past(host.addr[10]))
    else $error("parallel select with a10 high outside ecp");
  a_serial_disable:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      SERIAL_TWO_SELECT_O |-> $past(serial_port_two_base[7:6]) != 2'h0)
    else $error("serial two selected while disabled");
  a_density_invert:
    assert property (@(posedge REF_CLK_I) disable iff (RESET_I)
      $past(cur_type) == TYPE_INV_DENS |->
        DENSITY_OUT_ZERO_O == !$past(rate.density_select))
    else $error("inverted density not routed");

endmodule : iobad_top

`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench for the i/o base address decoder
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import iobad_pkg::*;
;
  logic        clk = 1'b0;   // 50 mhz
  logic        rst = 1'b1;   // sync reset
  logic        mode, iwr, dwr;
  logic [7:0]  wdata, rdata;
  iobad_host_t host;
  logic        pgood = 1'b0, epp = 1'b0, ecp = 1'b0;
  logic [1:0]  drv = 2'h0;
  logic        dens = 1'b0, r1 = 1'b0, r0 = 1'b0;
  logic        dz, d1;
  logic [6:0]  sel;          // game,fdc,idec,alt,par,s1,s2
  int          error_cnt = 0;
  int          total_checks = 0;
  logic [7:0]  rst_v [8] = '{8'h80, 8'h00, 8'h3c, 8'h3c, 8'h3d, 8'h00,
                             8'h00, 8'h00};
  logic [7:0]  ff_v [8] = '{8'hff, 8'hff, 8'hfc, 8'hfc, 8'hfd, 8'hff,
                            8'hfe, 8'hfe};
  logic [1:0]  t, e;

  initial
  begin
    forever #10 clk = ~clk;
  end

  iobad_host_model i_host (.clk_i(clk), .mode_o(mode), .idx_wr_o(iwr),
    .dat_wr_o(dwr), .wdata_o(wdata), .host_o(host));

  iobad_top i_dut (.REF_CLK_I(clk), .RESET_I(rst), .CFG_MODE_I(mode),
    .CFG_INDEX_WR_I(iwr), .CFG_DATA_WR_I(dwr), .CFG_WDATA_I(wdata),
    .CFG_RDATA_O(rdata), .HOST_SELECT_N_I(host.host_select_n),
    .HOST_ADDR_I(host.addr), .POWER_GOOD_CTRL_I(pgood),
    .EPP_MODE_I(epp), .ECP_MODE_I(ecp), .DRIVE_SEL_I(drv),
    .DENSITY_SELECT_I(dens), .RATE_BIT_ONE_I(r1), .RATE_BIT_ZERO_I(r0),
    .DENSITY_OUT_ZERO_O(dz), .DENSITY_OUT_ONE_O(d1),
    .GAME_PORT_SELECT_O(sel[6]), .FLOPPY_SELECT_O(sel[5]),
    .IDE_CONTROL_SELECT_O(sel[4]), .IDE_ALT_SELECT_O(sel[3]),
    .PARALLEL_SELECT_O(sel[2]), .SERIAL_ONE_SELECT_O(sel[1]),
    .SERIAL_TWO_SELECT_O(sel[0]));

  // register read-back comparison
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t register read %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  // output pin comparison (selects or density pair)
  task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t pins %b expected %b", $time, got, exp);
    end
  endtask : chk_pin

  // select index, let the registered read settle, compare
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    i_host.cfg_idx(idx);
    repeat (2) @(negedge clk);
    chk_reg(rdata, exp);
  endtask : rd

  // drive an address, wait out sync and output flop, compare
  task automatic probe(input logic n, input logic [10:0] a,
                       input logic [6:0] exp);
    i_host.io(n, a);
    repeat (4) @(negedge clk);
    chk_pin(sel, exp);
  endtask : probe

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
      rd(8'h1e + 8'(i), rst_v[i]);
    rd(8'h25, 8'h00);
    i_host.cfg_wr(1'b0, 8'h20, 8'h00);
    // read back shows zero while configuration mode is off
    chk_reg(rdata, 8'h00);
    rd(8'h20, 8'h3c);
    for (int i = 0; i < 8; i++)
    begin
      i_host.cfg_wr(1'b1, 8'h1e + 8'(i), 8'hff);
      rd(8'h1e + 8'(i), ff_v[i]);
    end
    i_host.cfg_wr(1'b1, 8'h26, 8'h55);
    rd(8'h26, 8'h00);
    // bases: game 200, fdc 3f0, ide 170, alt 376, par 378, 3f8, 2f8
    i_host.cfg_wr(1'b1, 8'h1e, 8'h81);
    i_host.cfg_wr(1'b1, 8'h20, 8'hfc);
    i_host.cfg_wr(1'b1, 8'h21, 8'h5c);
    i_host.cfg_wr(1'b1, 8'h22, 8'hdd);
    i_host.cfg_wr(1'b1, 8'h23, 8'hde);
    i_host.cfg_wr(1'b1, 8'h24, 8'hfe);
    i_host.cfg_wr(1'b1, 8'h25, 8'hbe);
    probe(1'b0, 11'h3f2, 7'b0100000);
    probe(1'b0, 11'h3f7, 7'b0100000);
    probe(1'b1, 11'h3f2, 7'b0000000);
    probe(1'b0, 11'h7f2, 7'b0000000);
    probe(1'b0, 11'h3f8, 7'b0000010);
    probe(1'b0, 11'h3ff, 7'b0000010);
    probe(1'b0, 11'h2fa, 7'b0000001);
    probe(1'b0, 11'h176, 7'b0010000);
    probe(1'b0, 11'h178, 7'b0000000);
    probe(1'b0, 11'h376, 7'b0001000);
    probe(1'b0, 11'h377, 7'b0000000);
    probe(1'b0, 11'h37b, 7'b0000100);
    probe(1'b0, 11'h37c, 7'b0000000);
    probe(1'b0, 11'h77a, 7'b0000000);
    epp = 1'b1;
    probe(1'b0, 11'h37f, 7'b0000100);
    epp = 1'b0;
    ecp = 1'b1;
    probe(1'b0, 11'h77a, 7'b0000100);
    ecp = 1'b0;
    probe(1'b0, 11'h201, 7'b1000000);
    probe(1'b0, 11'h202, 7'b0000000);
    probe(1'b0, 11'h601, 7'b0000000);
    i_host.cfg_wr(1'b1, 8'h1e, 8'h82);
    probe(1'b0, 11'h207, 7'b1000000);
    probe(1'b0, 11'h208, 7'b0000000);
    i_host.cfg_wr(1'b1, 8'h1e, 8'h83);
    probe(1'b0, 11'h20f, 7'b1000000);
    pgood = 1'b1;
    probe(1'b0, 11'h20f, 7'b0000000);
    pgood = 1'b0;
    i_host.cfg_wr(1'b1, 8'h1e, 8'h80);
    probe(1'b0, 11'h201, 7'b0000000);
    // base 030 would match 032 if the disable were ignored
    i_host.cfg_wr(1'b1, 8'h20, 8'h0c);
    probe(1'b0, 11'h032, 7'b0000000);
    // both serial ports on 3f8: overlapping selects pass through
    i_host.cfg_wr(1'b1, 8'h25, 8'hfe);
    probe(1'b0, 11'h3f9, 7'b0000011);
    // one drive of each type, two input patterns
    i_host.cfg_wr(1'b1, 8'h1f, 8'he4);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge clk);
      drv = 2'(k >> 1);
      {dens, r1, r0} = k[0] ? 3'b010 : 3'b101;
      t = 2'(8'he4 >> (2 * drv));
      case (t)
        2'h0: e = {dens, r0};
        2'h1: e = {r1, r0};
        2'h2: e = {~dens, r0};
        default: e = {r0, r1};
      endcase
      repeat (2) @(negedge clk);
      chk_pin({5'h00, dz, d1}, {5'h00, e});
    end
    give_verdict();
  end

  // watchdog: the sequence needs about three hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
